/* File: rtl/tec_pkg.sv */
package tec_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register byte offsets on the AXI4-Lite bus.
    localparam int ADDR_W = 8;
    localparam logic [7:0] CONTROL_OFS = 8'h00;
    localparam logic [7:0] TIMER_ASSIGN_OFS = 8'h04;
    localparam logic [7:0] RESULT_LOW_OFS = 8'h08;
    localparam logic [7:0] RESULT_HIGH_OFS = 8'h0C;
    localparam logic [7:0] IRQ_STATUS_OFS = 8'h10;
    localparam logic [7:0] IRQ_CLEAR_OFS = 8'h14;
    localparam logic [7:0] IRQ_ENABLE_OFS = 8'h18;

    ////////////////////////////////////////////////////////////////////////////////
    // Field positions and reset values.
    localparam int MODE_W = 4;
    localparam int CTRL_DIR_BIT = 4;
    localparam int CTRL_PORT_BIT = 5;
    localparam int CTRL_W = 6;
    localparam logic [CTRL_W-1:0] CONTROL_RESET = 6'h10;
    localparam int ASSIGN_CAP_BIT = 0;
    localparam int ASSIGN_PWM_LSB = 1;
    localparam int ASSIGN_W = 3;
    localparam logic [ASSIGN_W-1:0] ASSIGN_RESET = 3'h0;
    localparam int IRQ_CAPTURE_BIT = 0;
    localparam int IRQ_OVERRUN_BIT = 1;
    localparam int IRQ_W = 2;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;
    localparam int COUNT_W = 16;

    ////////////////////////////////////////////////////////////////////////////////
    // Mode select codes and prescale counts.
    localparam logic [MODE_W-1:0] MODE_CAP_FALL = 4'h4;
    localparam logic [MODE_W-1:0] MODE_CAP_RISE = 4'h5;
    localparam logic [MODE_W-1:0] MODE_CAP_RISE4 = 4'h6;
    localparam logic [MODE_W-1:0] MODE_CAP_RISE16 = 4'h7;
    localparam logic [MODE_W-1:0] MODE_CMP_FIRST = 4'h8;
    localparam logic [MODE_W-1:0] MODE_PWM_FIRST = 4'hC;
    localparam int PRESCALE_4 = 4;
    localparam int PRESCALE_16 = 16;

    ////////////////////////////////////////////////////////////////////////////////
    // Time base select codes and bus response codes.
    localparam logic [2:0] TB_NONE = 3'h0;
    localparam logic [2:0] TB_TIMER1 = 3'h1;
    localparam logic [2:0] TB_TIMER3 = 3'h3;
    localparam logic [2:0] TB_TIMER2 = 3'h2;
    localparam logic [2:0] TB_TIMER4 = 3'h4;
    localparam logic [2:0] TB_TIMER6 = 3'h6;
    localparam logic [2:0] TB_TIMER8 = 3'h7;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    function automatic logic tec_is_capture(input logic [MODE_W-1:0] mode);
        return (mode >= MODE_CAP_FALL) && (mode <= MODE_CAP_RISE16);
    endfunction

endpackage

/* File: rtl/tec_event_if.sv */
`timescale 1ns/100ps
interface tec_event_if;
    logic pin_level;
    logic [3:0] mode;
    logic capture_event;
    modport sense (input pin_level, input mode, output capture_event);
    modport user (output pin_level, output mode, input capture_event);
endinterface

/* File: rtl/tec_edge_prescaler.sv */
`timescale 1ns/100ps
module tec_edge_prescaler
    import tec_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    tec_event_if.sense ev
);

    logic prev_level;
    logic [MODE_W-1:0] prev_mode;
    logic [3:0] edge_count;
    logic capture_event_q;
    logic [3:0] next_edge_count;

    wire rise = ev.pin_level & ~prev_level;
    wire fall = ~ev.pin_level & prev_level;
    wire count_mode = (ev.mode == MODE_CAP_RISE4) || (ev.mode == MODE_CAP_RISE16);
    wire [3:0] wrap = (ev.mode == MODE_CAP_RISE4) ? 4'(PRESCALE_4 - 1) : 4'(PRESCALE_16 - 1);
    // RQ10: prescaler restart on change
    wire restart = (ev.mode != prev_mode) || !tec_is_capture(ev.mode);
    // RQ2: event type per mode
    wire fire = !restart && (((ev.mode == MODE_CAP_FALL) && fall)
        || ((ev.mode == MODE_CAP_RISE) && rise)
        || (count_mode && rise && (edge_count == wrap)));

    assign next_edge_count = restart ? 4'h0
        : (count_mode && rise) ? ((edge_count == wrap) ? 4'h0 : edge_count + 4'h1)
        : edge_count;
    assign ev.capture_event = capture_event_q;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            prev_level <= 1'b0;
            prev_mode <= 4'h0;
            edge_count <= 4'h0;
            capture_event_q <= 1'b0;
        end
        else
        begin
            prev_level <= ev.pin_level;
            prev_mode <= ev.mode;
            edge_count <= next_edge_count;
            capture_event_q <= fire;
        end
    end

endmodule // tec_edge_prescaler

/* File: rtl/tec_capture.sv */
`timescale 1ns/100ps
// Summary of operation
// RQ1: Capture copies selected 16-bit timer count.
// RQ2: Mode selects falling, rising, fourth, sixteenth edge.
// RQ3: Capture sets flag; only software clears it.
// RQ4: New capture overwrites unread old result.
// RQ5: Assignment register picks timer one or three.
// RQ6: Software runs timer in synchronous mode.
// RQ7: Software makes pin input and routes it.
// RQ8: Detection samples real pin level, even driven.
// RQ9: Compare uses timer one/three; PWM others.
// RQ10: Prescaler clears on mode change or disable.
module tec_capture
    import tec_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic capture_input_pin_in,
    output logic capture_input_pin_out,
    output logic capture_input_pin_oe_n,
    input wire logic [COUNT_W-1:0] timer_one_count,
    input wire logic [COUNT_W-1:0] timer_three_count,
    output logic [2:0] time_base_sel,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // Register state.

    logic [CTRL_W-1:0] capture_control_reg;
    logic [ASSIGN_W-1:0] timer_assignment_reg;
    logic [COUNT_W-1:0] capture_result;
    logic result_unread;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_enable;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchroniser and edge prescaler.

    logic pin_meta;
    logic pin_sync;

    tec_event_if ev ();

    // RQ8: sample actual pad
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
        end
        else
        begin
            pin_meta <= capture_input_pin_in;
            pin_sync <= pin_meta;
        end
    end

    assign ev.pin_level = pin_sync;
    assign ev.mode = capture_control_reg[MODE_W-1:0];

    tec_edge_prescaler u_prescaler (
        .clk (clk),
        .reset (reset),
        .ev (ev.sense)
    );

    wire capture_event = ev.capture_event;

    // The pin is driven only when the direction bit selects output.
    assign capture_input_pin_out = capture_control_reg[CTRL_PORT_BIT];
    assign capture_input_pin_oe_n = capture_control_reg[CTRL_DIR_BIT];

    ////////////////////////////////////////////////////////////////////////////////
    // Time base selection.

    wire use_timer_three = timer_assignment_reg[ASSIGN_CAP_BIT];
    wire [1:0] pwm_pick = timer_assignment_reg[ASSIGN_PWM_LSB +: 2];
    wire [MODE_W-1:0] mode = capture_control_reg[MODE_W-1:0];
    wire mode_active = tec_is_capture(mode) || (mode >= MODE_CMP_FIRST);
    wire mode_pwm = mode >= MODE_PWM_FIRST;
    wire [2:0] cc_base = use_timer_three ? TB_TIMER3 : TB_TIMER1;
    wire [2:0] pwm_base = (pwm_pick == 2'h0) ? TB_TIMER2
        : (pwm_pick == 2'h1) ? TB_TIMER4
        : (pwm_pick == 2'h2) ? TB_TIMER6
        : TB_TIMER8;

    // RQ9: compare and PWM bases
    assign time_base_sel = !mode_active ? TB_NONE : (mode_pwm ? pwm_base : cc_base);

    // RQ5: timer one or three
    wire [COUNT_W-1:0] selected_count = use_timer_three ? timer_three_count : timer_one_count;

    function automatic logic reg_is_mapped(input logic [ADDR_W-1:0] ofs);
        return (ofs == CONTROL_OFS) || (ofs == TIMER_ASSIGN_OFS)
            || (ofs == RESULT_LOW_OFS) || (ofs == RESULT_HIGH_OFS)
            || (ofs == IRQ_STATUS_OFS) || (ofs == IRQ_CLEAR_OFS)
            || (ofs == IRQ_ENABLE_OFS);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel.

    logic aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;

    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire write_go = aw_held && w_held && !s_axi_bvalid;
    wire wr_lane0 = write_go && w_strb[0];
    wire wr_control = wr_lane0 && (aw_addr == CONTROL_OFS);
    wire wr_assign = wr_lane0 && (aw_addr == TIMER_ASSIGN_OFS);
    wire wr_clear = wr_lane0 && (aw_addr == IRQ_CLEAR_OFS);
    wire wr_enable = wr_lane0 && (aw_addr == IRQ_ENABLE_OFS);
    wire wr_mapped = reg_is_mapped(aw_addr);

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            aw_held <= 1'b0;
        end
        else if (aw_take)
        begin
            aw_held <= 1'b1;
        end
        else if (write_go)
        begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            aw_addr <= '0;
        end
        else if (aw_take)
        begin
            aw_addr <= s_axi_awaddr;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            w_held <= 1'b0;
        end
        else if (w_take)
        begin
            w_held <= 1'b1;
        end
        else if (write_go)
        begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            w_data <= '0;
            w_strb <= '0;
        end
        else if (w_take)
        begin
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else if (write_go)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Control registers written by software.

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            capture_control_reg <= CONTROL_RESET;
        end
        else if (wr_control)
        begin
            capture_control_reg <= w_data[CTRL_W-1:0];
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            timer_assignment_reg <= ASSIGN_RESET;
        end
        else if (wr_assign)
        begin
            timer_assignment_reg <= w_data[ASSIGN_W-1:0];
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            irq_enable <= IRQ_RESET;
        end
        else if (wr_enable)
        begin
            irq_enable <= w_data[IRQ_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel.

    logic [31:0] read_word;
    logic read_ok;

    assign s_axi_arready = !s_axi_rvalid;
    wire ar_take = s_axi_arvalid && s_axi_arready;
    wire rd_high = ar_take && (s_axi_araddr == RESULT_HIGH_OFS);

    always_comb
    begin
        read_word = 32'h0;
        read_ok = reg_is_mapped(s_axi_araddr);
        case (s_axi_araddr)
            CONTROL_OFS: read_word[CTRL_W-1:0] = capture_control_reg;
            TIMER_ASSIGN_OFS: read_word[ASSIGN_W-1:0] = timer_assignment_reg;
            RESULT_LOW_OFS: read_word[7:0] = capture_result[7:0];
            RESULT_HIGH_OFS: read_word[7:0] = capture_result[15:8];
            IRQ_STATUS_OFS: read_word[IRQ_W-1:0] = irq_status;
            IRQ_CLEAR_OFS: read_word = 32'h0;
            IRQ_ENABLE_OFS: read_word[IRQ_W-1:0] = irq_enable;
            default: read_word = 32'h0;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (ar_take)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= read_word;
            s_axi_rresp <= read_ok ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Capture result and interrupt flags.

    logic [IRQ_W-1:0] set_mask;
    logic [IRQ_W-1:0] clear_mask;
    logic [IRQ_W-1:0] next_irq_status;

    // RQ4: overwrite flagged as overrun
    assign set_mask = {capture_event && result_unread, capture_event};
    assign clear_mask = wr_clear ? w_data[IRQ_W-1:0] : '0;
    // RQ3: only software clears; set wins
    assign next_irq_status = (irq_status & ~clear_mask) | set_mask;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            irq_status <= IRQ_RESET;
        end
        else
        begin
            irq_status <= next_irq_status;
        end
    end

    // RQ1: latch full timer count
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            capture_result <= '0;
        end
        else if (capture_event)
        begin
            capture_result <= selected_count;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            result_unread <= 1'b0;
        end
        else
        begin
            result_unread <= capture_event || (result_unread && !rd_high);
        end
    end

    assign irq = |(irq_status & irq_enable);

endmodule // tec_capture

/* File: tb/tec_capture_props.sv */
`timescale 1ns/100ps
module tec_capture_props (
    input wire logic clk,
    input wire logic reset,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic capture_input_pin_out,
    input wire logic capture_input_pin_oe_n,
    input wire logic [2:0] time_base_sel,
    input wire logic irq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    r_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    w_latency_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write answer not two cycles");
    w_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    r_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
    irq_sticky_a: assert property ($fell(irq) |-> $rose(s_axi_bvalid))
        else $error("interrupt fell without a write");
    pin_drive_a: assert property ($changed(capture_input_pin_out) ||
        $changed(capture_input_pin_oe_n) |-> $rose(s_axi_bvalid))
        else $error("pin drive changed without a write");
    base_write_a: assert property ($changed(time_base_sel) |-> $rose(s_axi_bvalid))
        else $error("time base changed without a write");
    base_legal_a: assert property (time_base_sel != 3'h5)
        else $error("time base code unused");
endmodule // tec_capture_props

bind tec_capture tec_capture_props u_props (.clk, .reset, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .capture_input_pin_out,
    .capture_input_pin_oe_n, .time_base_sel, .irq);

/* File: tb/tec_pin_source.sv */
`timescale 1ns/100ps
module tec_pin_source (
    input wire logic src_level,
    input wire logic pin_out,
    input wire logic pin_oe_n,
    output logic pad
);
    // pad level
    // The source drives only while the port is an input; a driven port loops back to the pad.
    assign pad = pin_oe_n ? src_level : pin_out;
endmodule // tec_pin_source

/* File: tb/testbench.sv */
`timescale 1ns/100ps
module testbench;
    import tec_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [ADDR_W-1:0] s_axi_awaddr = '0;
    logic [ADDR_W-1:0] s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_rready = 1'b0;
    logic src_level = 1'b0;
    logic [COUNT_W-1:0] t1 = '0;
    logic [COUNT_W-1:0] t3 = '0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, pad;
    logic pin_out, pin_oe_n;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [2:0] time_base_sel;
    int err_count = 0;
    int n_compared = 0;

    always #4 clk = ~clk;

    tec_capture u_tec_capture (.clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .capture_input_pin_in(pad),
        .capture_input_pin_out(pin_out), .capture_input_pin_oe_n(pin_oe_n),
        .timer_one_count(t1), .timer_three_count(t3), .time_base_sel, .irq);
    tec_pin_source u_tec_pin_source (.src_level, .pin_out, .pin_oe_n, .pad);

    ////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test;
        $display("mismatches %0d compares %0d", err_count, n_compared);
        if (err_count == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY,
        input logic [3:0] st = 4'hF);
        logic ha;
        logic hw;
        logic hb;
        logic [1:0] br;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(negedge clk);
            ha = s_axi_awvalid && s_axi_awready;
            hw = s_axi_wvalid && s_axi_wready;
            hb = s_axi_bvalid;
            br = s_axi_bresp;
            @(posedge clk);
            s_axi_awvalid <= s_axi_awvalid && !ha;
            s_axi_wvalid <= s_axi_wvalid && !hw;
        end while (!hb);
        s_axi_bready <= 1'b0;
        chk({br, 32'h0}, {er, 32'h0});
        @(posedge clk);
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er = RESP_OKAY);
        logic ha;
        logic hr;
        logic [33:0] got;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(negedge clk);
            ha = s_axi_arvalid && s_axi_arready;
            hr = s_axi_rvalid;
            got = {s_axi_rresp, s_axi_rdata};
            @(posedge clk);
            s_axi_arvalid <= s_axi_arvalid && !ha;
        end while (!hr);
        s_axi_rready <= 1'b0;
        chk(got, {er, ed});
        @(posedge clk);
    endtask

    task automatic pulse(input int n);
        repeat (n)
        begin
            src_level <= 1'b1;
            repeat (5) @(posedge clk);
            src_level <= 1'b0;
            repeat (5) @(posedge clk);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        rc(CONTROL_OFS, 32'h10);
        wr(CONTROL_OFS, 32'h05, RESP_OKAY, 4'hE);
        rc(CONTROL_OFS, 32'h10);
        rc(TIMER_ASSIGN_OFS, 32'h0);
        rc(IRQ_STATUS_OFS, 32'h0);
        rc(IRQ_ENABLE_OFS, 32'h0);
        rc(8'h1C, 32'h0, RESP_SLVERR);
        wr(8'h1C, 32'h1, RESP_SLVERR);
        wr(IRQ_STATUS_OFS, 32'h3);
        rc(IRQ_STATUS_OFS, 32'h0);
        chk({33'h0, pin_oe_n}, 34'h1);
    endtask

    task automatic t_modes;
        logic [15:0] e;
        for (int i = 0; i < 4; i++)
        begin
            t1 <= 16'hA5C0 + 16'(i);
            t3 <= 16'h5A30 + 16'(i);
            e = i[0] ? 16'h5A30 + 16'(i) : 16'hA5C0 + 16'(i);
            wr(TIMER_ASSIGN_OFS, 32'(i % 2));
            wr(CONTROL_OFS, 32'h14 + 32'(i));
            pulse(i < 2 ? 0 : (i == 2 ? 3 : 15));
            rc(IRQ_STATUS_OFS, 32'h0);
            src_level <= 1'b1;
            repeat (5) @(posedge clk);
            rc(IRQ_STATUS_OFS, i == 0 ? 32'h0 : 32'h1);
            src_level <= 1'b0;
            repeat (5) @(posedge clk);
            rc(IRQ_STATUS_OFS, 32'h1);
            rc(RESULT_LOW_OFS, {24'h0, e[7:0]});
            rc(RESULT_HIGH_OFS, {24'h0, e[15:8]});
            wr(IRQ_CLEAR_OFS, 32'h3);
        end
    endtask

    task automatic t_overrun;
        wr(CONTROL_OFS, 32'h15);
        wr(TIMER_ASSIGN_OFS, 32'h0);
        wr(IRQ_ENABLE_OFS, 32'h1);
        t1 <= 16'h1111;
        pulse(1);
        chk({33'h0, irq}, 34'h1);
        t1 <= 16'h2468;
        pulse(1);
        rc(RESULT_LOW_OFS, 32'h68);
        rc(IRQ_STATUS_OFS, 32'h3);
        rc(RESULT_HIGH_OFS, 32'h24);
        repeat (50) @(posedge clk);
        rc(IRQ_STATUS_OFS, 32'h3);
        wr(IRQ_ENABLE_OFS, 32'h0);
        chk({33'h0, irq}, 34'h0);
        wr(IRQ_CLEAR_OFS, 32'h1);
        rc(IRQ_STATUS_OFS, 32'h2);
        wr(IRQ_ENABLE_OFS, 32'h2);
        chk({33'h0, irq}, 34'h1);
        wr(IRQ_CLEAR_OFS, 32'h2);
        chk({33'h0, irq}, 34'h0);
    endtask

    task automatic t_drive;
        wr(CONTROL_OFS, 32'h05);
        chk({33'h0, pin_oe_n}, 34'h0);
        wr(CONTROL_OFS, 32'h25);
        repeat (5) @(posedge clk);
        chk({33'h0, pin_out}, 34'h1);
        rc(IRQ_STATUS_OFS, 32'h1);
        rc(RESULT_HIGH_OFS, 32'h24);
        wr(IRQ_CLEAR_OFS, 32'h1);
        wr(CONTROL_OFS, 32'h15);
    endtask

    task automatic t_prescale;
        t1 <= 16'hBEEF;
        wr(CONTROL_OFS, 32'h16);
        pulse(2);
        wr(CONTROL_OFS, 32'h17);
        wr(CONTROL_OFS, 32'h16);
        pulse(3);
        rc(IRQ_STATUS_OFS, 32'h0);
        pulse(1);
        rc(IRQ_STATUS_OFS, 32'h1);
        rc(RESULT_LOW_OFS, 32'hEF);
        wr(IRQ_CLEAR_OFS, 32'h1);
        wr(CONTROL_OFS, 32'h10);
        pulse(1);
        rc(IRQ_STATUS_OFS, 32'h0);
    endtask

    task automatic t_base;
        logic [11:0] tab [6] = '{12'h801, 12'h813, 12'hC02, 12'hC24, 12'hC46, 12'hC67};
        for (int j = 0; j < 6; j++)
        begin
            wr(TIMER_ASSIGN_OFS, {28'h0, tab[j][7:4]});
            wr(CONTROL_OFS, {24'h0, 4'h1, tab[j][11:8]});
            chk({31'h0, time_base_sel}, {31'h0, tab[j][2:0]});
        end
        wr(CONTROL_OFS, 32'h10);
        chk({31'h0, time_base_sel}, 34'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        t_regs;
        t_modes;
        t_overrun;
        t_drive;
        t_prescale;
        t_base;
        stop_test;
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        err_count++;
        stop_test;
    end
endmodule // testbench
